// *** core/fars_pkg.sv ***
package fars_pkg;
  // Register byte addresses (select registers: write side and read side differ)
  localparam logic [7:0] ADDR_SEL_A_WR = 8'h00;
  localparam logic [7:0] ADDR_SEL_B_WR = 8'h04;
  localparam logic [7:0] ADDR_SEL_A_RD = 8'h80;
  localparam logic [7:0] ADDR_SEL_B_RD = 8'h84;
  localparam logic [7:0] ADDR_CLEAR    = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h88;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h90;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h94;

  // Field positions (low bit of each 3-bit field)
  localparam int POS_PUMP_OV  = 12;
  localparam int POS_LOGIC_OV = 8;
  localparam int POS_AMP_OV   = 4;
  localparam int POS_AMP_UV   = 0;
  localparam int POS_TEMP     = 8;
  localparam int POS_OSC      = 4;
  localparam int POS_BATT_UV  = 0;

  // Reset values and writable-bit masks
  localparam logic [15:0] RST_SEL_A  = 16'h0200;
  localparam logic [15:0] RST_SEL_B  = 16'h0200;
  localparam logic [15:0] MASK_SEL_A = 16'h7777;
  localparam logic [15:0] MASK_SEL_B = 16'h0777;

  // Select field geometry: 3-bit codes on a 4-bit stride
  localparam int FIELD_W      = 3;
  localparam int FIELD_STRIDE = 4;
  localparam int NUM_FIELDS   = 4;

  // Detector index order, shared by status, clear and interrupt words
  localparam int NUM_DET   = 7;
  localparam int DET_PUMP  = 0;
  localparam int DET_LOGIC = 1;
  localparam int DET_AMPOV = 2;
  localparam int DET_AMPUV = 3;
  localparam int DET_TEMP  = 4;
  localparam int DET_OSC   = 5;
  localparam int DET_BATT  = 6;

  // Generic action codes
  localparam logic [2:0] ACT_OFF       = 3'h0;
  localparam logic [2:0] ACT_FLAG      = 3'h1;
  localparam logic [2:0] ACT_ALL_OFF   = 3'h2;
  localparam logic [2:0] ACT_MOTOR_OFF = 3'h3;
  localparam logic [2:0] ACT_PUMP_OFF  = 3'h4;
  localparam logic [2:0] ACT_HOLD_ALL  = 3'h5;
  localparam logic [2:0] ACT_MAX       = 3'h5;

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// *** core/fars_regs.sv ***
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Unassigned bits ignore writes and always read back as zero.
// - First select register written at 00h, read at 80h.
// - Second select register written at 04h, read at 84h.
// - Code 000 disables detection; 001 latches flag low, operation continues.
// - Code 010 latches flag, all drivers off; 011 latches flag, motor off.
// - Code 100 adds pump off; 101 also latches driver-off and pump-off.
// - First register bits 14:12 select pump rail overvoltage response.
// - First register bits 10:8 select logic supply overvoltage; resets 010.
// - First register bits 6:4 select amplifier supply overvoltage response.
// - First register bits 2:0 select amplifier supply undervoltage response.
// - Second register bits 10:8 select overtemperature response; resets 010.
// - Second register bits 6:4 select oscillator fault response.
// - Battery field: 0-2 all off, 3-5 motor off; flag latched, live, high.
// - An undefined code leaves its field unchanged; other fields update.
// - Latched state holds until fault gone and software writes clear, or until its field is moved to a non-latching code.
module fars_regs (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [6:0]  fault_det_in,
  output logic             fault_flag_out,
  output logic             fault_flag_oe_out,
  output logic             all_drivers_off_out,
  output logic             motor_drivers_off_out,
  output logic             pump_stop_out,
  output logic             irq_out
);

  localparam int N = fars_pkg::NUM_DET;

  // Timing through the block, counted in clock edges from a detector
  // change: two edges of synchroniser, then the live path reaches the
  // registered driver outputs on the third edge. A latched flag needs one
  // edge more, since its hold bit is a flop ahead of the pin stage.
  // Registering the flag and driver pins costs this small fixed delay, which is far
  // below any filter time on the analog detector side.
  // Reset is synchronous: every register, the synchroniser included,
  // returns to its reset state at the first edge with reset high, and
  // the flag pin then reads high with its driver released. The select
  // words come back with only the two default fields and the battery field armed.

  // Register state, synchroniser stages and bus bookkeeping
  logic [15:0]  fault_action_sel_a;
  logic [15:0]  fault_action_sel_b;
  logic [N-1:0] det_meta;
  logic [N-1:0] det;
  logic [N-1:0] flag_hold;
  logic [N-1:0] drv_hold;
  logic [N-1:0] irq_status;
  logic [N-1:0] irq_mask;
  logic [N-1:0] clear_req;
  logic [N-1:0] irq_clear;
  logic [N-1:0] det_rise;
  logic [N-1:0] det_last;
  logic [2:0]   act [N];
  logic         wr_pend;
  logic [7:0]   wr_addr;
  logic [15:0]  next_sel_a;
  logic [15:0]  next_sel_b;
  logic         wr_now;

  // Detector levels come from analog comparators, so synchronise twice
  // Only the second stage is read anywhere; the first may go metastable
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      det_meta <= '0;
      det      <= '0;
    end
    else
    begin
      det_meta <= fault_det_in;
      det      <= det_meta;
    end
  end

  // Address phase capture; slave is always ready, response always OKAY
  // Only the low address byte is decoded, so the map repeats every 256
  // bytes; software must not rely on upper address bits to separate
  // anything. Writes of other than a whole word are dropped here.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready_in)
    begin
      wr_pend <= hsel_in && hwrite_in && htrans_in == fars_pkg::HTRANS_NONSEQ
                 && hsize_in == fars_pkg::HSIZE_WORD;
      wr_addr <= haddr_in[7:0];
    end
  end

  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign wr_now        = wr_pend;

  // Field-wise merge: an undefined code keeps the old field
  // Each field is judged on its own, so one bad code in a write does not
  // cost the good codes beside it. Bits outside every field stay zero,
  // because the mask clears them before any field is copied in.
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] keep);
    logic [15:0] r;
    int          lo;
    r = old_v & keep;
    for (int f = 0; f < fars_pkg::NUM_FIELDS; f++)
    begin
      lo = fars_pkg::FIELD_STRIDE * f;
      if (keep[lo])
      begin
        if (new_v[lo +: fars_pkg::FIELD_W] <= fars_pkg::ACT_MAX)
          r[lo +: fars_pkg::FIELD_W] = new_v[lo +: fars_pkg::FIELD_W];
        else
          r[lo +: fars_pkg::FIELD_W] = old_v[lo +: fars_pkg::FIELD_W];
      end
    end
    return r;
  endfunction

  assign next_sel_a = merge(fault_action_sel_a, hwdata_in[15:0],
                            fars_pkg::MASK_SEL_A);
  assign next_sel_b = merge(fault_action_sel_b, hwdata_in[15:0],
                            fars_pkg::MASK_SEL_B);

  // Select word A: pump rail, logic supply and amplifier supply fields
  // Write at 00h
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      fault_action_sel_a <= fars_pkg::RST_SEL_A;
    else if (wr_now && wr_addr == fars_pkg::ADDR_SEL_A_WR)
      fault_action_sel_a <= next_sel_a;
  end

  // Select word B: overtemperature, oscillator and battery fields
  // Write at 04h
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      fault_action_sel_b <= fars_pkg::RST_SEL_B;
    else if (wr_now && wr_addr == fars_pkg::ADDR_SEL_B_WR)
      fault_action_sel_b <= next_sel_b;
  end

  // Field extraction per detector; the index order matches the status,
  // clear and interrupt words, so one detector number names one bit
  // position everywhere in the block.
  // Pump rail field
  assign act[fars_pkg::DET_PUMP]  =
    fault_action_sel_a[fars_pkg::POS_PUMP_OV +: 3];
  assign act[fars_pkg::DET_LOGIC] =
    fault_action_sel_a[fars_pkg::POS_LOGIC_OV +: 3];
  assign act[fars_pkg::DET_AMPOV] =
    fault_action_sel_a[fars_pkg::POS_AMP_OV +: 3];
  assign act[fars_pkg::DET_AMPUV] =
    fault_action_sel_a[fars_pkg::POS_AMP_UV +: 3];
  assign act[fars_pkg::DET_TEMP]  =
    fault_action_sel_b[fars_pkg::POS_TEMP +: 3];
  assign act[fars_pkg::DET_OSC]   =
    fault_action_sel_b[fars_pkg::POS_OSC +: 3];
  assign act[fars_pkg::DET_BATT]  =
    fault_action_sel_b[fars_pkg::POS_BATT_UV +: 3];

  // Clear request from the clear word; only takes effect once fault is gone
  // Clear bits act as strobes: they live only in the write data phase and
  // need no write of zero afterwards.
  assign clear_req = (wr_now && wr_addr == fars_pkg::ADDR_CLEAR)
                     ? hwdata_in[N-1:0] : '0;
  assign irq_clear = (wr_now && wr_addr == fars_pkg::ADDR_IRQ_STAT)
                     ? hwdata_in[N-1:0] : '0;

  // Per-detector decode of latch kinds.
  // Generic fields: any code but 000 arms detection and latches the flag;
  // the driver choice rises from motor-only to all nine with pump stop.
  // Battery field: the code picks the driver group (all or motor) and the
  // flag style (held, live or left high); detection is never disabled,
  // and neither the drivers nor the pump are ever held for this source.
  logic [N-1:0] en_det;
  logic [N-1:0] flag_latch;
  logic [N-1:0] flag_live;
  logic [N-1:0] off_all;
  logic [N-1:0] off_motor;
  logic [N-1:0] pump_off;
  logic [N-1:0] drv_latch;

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      en_det[i]     = 1'b0;
      flag_latch[i] = 1'b0;
      flag_live[i]  = 1'b0;
      off_all[i]    = 1'b0;
      off_motor[i]  = 1'b0;
      pump_off[i]   = 1'b0;
      drv_latch[i]  = 1'b0;
      if (i == fars_pkg::DET_BATT)
      begin
        en_det[i]     = 1'b1;
        off_all[i]    = act[i] <= fars_pkg::ACT_ALL_OFF;
        off_motor[i]  = !off_all[i];
        flag_latch[i] = act[i] == fars_pkg::ACT_OFF
                        || act[i] == fars_pkg::ACT_MOTOR_OFF;
        flag_live[i]  = act[i] == fars_pkg::ACT_FLAG
                        || act[i] == fars_pkg::ACT_PUMP_OFF;
      end
      else
      begin
        en_det[i]     = act[i] != fars_pkg::ACT_OFF;
        flag_latch[i] = en_det[i];
        off_all[i]    = act[i] == fars_pkg::ACT_ALL_OFF
                        || act[i] == fars_pkg::ACT_PUMP_OFF
                        || act[i] == fars_pkg::ACT_HOLD_ALL;
        off_motor[i]  = act[i] == fars_pkg::ACT_MOTOR_OFF;
        pump_off[i]   = act[i] == fars_pkg::ACT_PUMP_OFF
                        || act[i] == fars_pkg::ACT_HOLD_ALL;
        drv_latch[i]  = act[i] == fars_pkg::ACT_HOLD_ALL;
      end
    end
  end

  // A clear that arrives while the detector still reports the fault is
  // lost, not deferred: software must clear again once the fault is gone.
  // Moving a field to a code that does not latch drops its hold at once,
  // which releases a hold even with the fault still present.
  // Latched flag and latched driver state
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      flag_hold <= '0;
      drv_hold  <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        // Set wins over clear: a present fault blocks the clear
        if (det[i] && flag_latch[i])
          flag_hold[i] <= 1'b1;
        else if (clear_req[i] || !flag_latch[i])
          flag_hold[i] <= 1'b0;
        if (det[i] && drv_latch[i])
          drv_hold[i] <= 1'b1;
        else if (clear_req[i] || !drv_latch[i])
          drv_hold[i] <= 1'b0;
      end
    end
  end

  // The driver hold bit counts as a live detector for the output stage,
  // so a held all-off keeps the pump stopped only where the field asks.
  // Live outputs follow the detector; latched ones hold
  logic [N-1:0] active;
  logic [N-1:0] flag_low;
  assign active   = (det & en_det) | drv_hold;
  assign flag_low = flag_hold | (det & flag_live);

  // Output pins registered; flag is open-drain, driven only when low
  // Registering keeps decode glitches off the pins when a field is
  // rewritten while a detector is active.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      fault_flag_out        <= 1'b1;
      fault_flag_oe_out     <= 1'b0;
      all_drivers_off_out   <= 1'b0;
      motor_drivers_off_out <= 1'b0;
      pump_stop_out         <= 1'b0;
    end
    else
    begin
      fault_flag_out        <= ~|flag_low;
      fault_flag_oe_out     <= |flag_low;
      all_drivers_off_out   <= |(active & (off_all | drv_hold));
      motor_drivers_off_out <= |(active & (off_all | off_motor | drv_hold));
      pump_stop_out         <= |(active & pump_off);
    end
  end

  // Sticky interrupt status, set on detector rise, write one to clear
  // An event is a rising edge of the synchronised level, so a fault that
  // stays present raises only one interrupt until it goes and comes back.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      det_last   <= '0;
      irq_status <= '0;
    end
    else
    begin
      det_last   <= det;
      irq_status <= (irq_status & ~irq_clear) | det_rise;
    end
  end
  assign det_rise = det & ~det_last & en_det;

  // Interrupt mask register; a one blocks that detector's interrupt
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      irq_mask <= '0;
    else if (wr_now && wr_addr == fars_pkg::ADDR_IRQ_MASK)
      irq_mask <= hwdata_in[N-1:0];
  end

  // Level interrupt, high while any unmasked status bit is set
  // Masking hides the line only; the status bits still record events
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status & ~irq_mask);
  end

  // Read data registered in the address phase, so it stands in data phase
  // Write-side offsets and unmapped offsets read as zero, and a read has
  // no side effects: no status bit is cleared by looking at it.
  // The read side ignores the transfer size, so narrow reads see the word.
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      hrdata_out <= 32'h0000_0000;
    else if (hready_in && hsel_in && !hwrite_in
             && htrans_in == fars_pkg::HTRANS_NONSEQ)
    begin
      hrdata_out <= 32'h0000_0000;
      case (haddr_in[7:0])
        fars_pkg::ADDR_SEL_A_RD: hrdata_out[15:0] <= fault_action_sel_a;
        fars_pkg::ADDR_SEL_B_RD: hrdata_out[15:0] <= fault_action_sel_b;
        fars_pkg::ADDR_STATUS:   hrdata_out[N-1:0] <= flag_hold | det;
        fars_pkg::ADDR_IRQ_STAT: hrdata_out[N-1:0] <= irq_status;
        fars_pkg::ADDR_IRQ_MASK: hrdata_out[N-1:0] <= irq_mask;
        default:                 hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// *** test/fars_chk_sva.sv ***
`timescale 1ns/1ps
module fars_chk (
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [6:0]  fault_det_in,
  input wire logic        fault_flag_out,
  input wire logic        fault_flag_oe_out,
  input wire logic        all_drivers_off_out,
  input wire logic        motor_drivers_off_out,
  input wire logic        pump_stop_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  // Read address phase taken by the slave
  wire rd = hsel_in && hready_in && !hwrite_in &&
    htrans_in == fars_pkg::HTRANS_NONSEQ;
  sequence rd_at(a);
    rd && haddr_in == a;
  endsequence
  // Five quiet samples cover the sync and output stages
  sequence quiet;
    (fault_det_in == 7'h00) [*5];
  endsequence
  chk_bus_okay:
    assert property (hreadyout_out && !hresp_out) else $error("bus not okay");
  chk_data_holds:
    assert property (!rd |=> $stable(hrdata_out))
    else $error("read data moved without a read");
  chk_sel_a_bits:
    assert property (rd_at(32'h80) |=> !(hrdata_out & 32'hffff8888))
    else $error("unassigned bit of sel a set");
  chk_sel_b_bits:
    assert property (rd_at(32'h84) |=> !(hrdata_out & 32'hfffff888))
    else $error("unassigned bit of sel b set");
  chk_wr_side_zero:
    assert property (rd_at(32'h0) or rd_at(32'h4) |=> hrdata_out == 32'h0)
    else $error("write address read nonzero");
  chk_oe_pairs:
    assert property (fault_flag_oe_out == !fault_flag_out)
    else $error("flag enable disagrees with flag");
  chk_motor_w_all:
    assert property (all_drivers_off_out |-> motor_drivers_off_out)
    else $error("all off without motor off");
  chk_pump_w_all:
    assert property (pump_stop_out |-> all_drivers_off_out)
    else $error("pump stop without all off");
  chk_quiet_release:
    assert property (quiet ##0 fault_flag_out |->
      !all_drivers_off_out && !motor_drivers_off_out && !pump_stop_out)
    else $error("drivers held with flag high and no fault");
endmodule
bind fars_regs fars_chk fars_chk_i (.clk_sys_in, .reset_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out,
  .hresp_out, .fault_det_in, .fault_flag_out, .fault_flag_oe_out,
  .all_drivers_off_out, .motor_drivers_off_out, .pump_stop_out);

// *** test/fars_regs_test.sv ***
`timescale 1ns/1ps
module fars_regs_test;
  logic        clk_sys_in, reset_in, hsel_in, hwrite_in, hreadyout_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rdv;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [6:0]  fault_det_in;
  logic        hresp_out, fault_flag_out, fault_flag_oe_out, irq_out;
  logic        all_drivers_off_out, motor_drivers_off_out, pump_stop_out;
  logic [5:0]  obs;
  int          mismatches, n_checks;
  int          cycles = 0;
  int          pos[7] = '{12, 8, 4, 0, 8, 4, 0};
  // Rows: write addr, write data, read addr, expected low half
  logic [63:0] rows[17] = '{64'h00_ffff8888_80_0000, 64'h00_00001111_80_1111,
    64'h00_00002222_80_2222, 64'h00_00003333_80_3333, 64'h00_00004444_80_4444,
    64'h00_00005555_80_5555, 64'h00_00007016_80_5015, 64'h80_00000000_80_5015,
    64'h04_ffff8000_84_0000, 64'h04_00000111_84_0111, 64'h04_00000222_84_0222,
    64'h04_00000333_84_0333, 64'h04_00000444_84_0444, 64'h04_00000555_84_0555,
    64'h04_0000f7f6_84_0555, 64'h40_12345678_40_0000, 64'h00_00000000_00_0000};

  fars_regs fars_regs_i (.clk_sys_in, .reset_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out, .fault_det_in, .fault_flag_out,
    .fault_flag_oe_out, .all_drivers_off_out, .motor_drivers_off_out,
    .pump_stop_out, .irq_out);
  // Flag, enable, all off, motor off, pump stop, interrupt
  assign obs = {fault_flag_out, fault_flag_oe_out, all_drivers_off_out,
    motor_drivers_off_out, pump_stop_out, irq_out};

  // Free running system clock
  initial
  begin
    clk_sys_in = 0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // A hang counts against the run
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // Single transfer; no wait count assumed, only the timeout ends a stall
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
    htrans_in <= fars_pkg::HTRANS_NONSEQ;
    haddr_in <= a;
    hwrite_in <= wr;
    tick(1);
    while (hreadyout_out !== 1'b1)
      tick(1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    tick(1);
    while (hreadyout_out !== 1'b1)
      tick(1);
    rdv = hrdata_out;
  endtask

  // Expected outputs for detector d, code c, fault live or gone
  function automatic logic [5:0] exp_out(int d, int c, bit live);
    logic f, a, m, p;
    if (d == 6)
    begin
      f = live ? (c % 3 != 2) : (c % 3 == 0);
      a = live && c < 3;
      m = live;
      p = 0;
    end
    else
    begin
      f = c != 0;
      a = c == 5 || (live && (c == 2 || c == 4));
      m = a || (live && c == 3);
      p = c == 5 || (live && c == 4);
    end
    return {!f, f, a, m, p, d == 6 || c != 0};
  endfunction

  initial
  begin
    reset_in = 1;
    hsel_in = 1;
    haddr_in = 0;
    htrans_in = 0;
    hwrite_in = 0;
    hsize_in = fars_pkg::HSIZE_WORD;
    hwdata_in = 0;
    fault_det_in = 0;
    mismatches = 0;
    n_checks = 0;
    tick(6);
    reset_in <= 0;
    tick(1);
    check("reset outputs", obs, 6'h20);
    bus(0, 32'h80, 0);
    check("sel a reset", rdv, 32'h200);
    bus(0, 32'h84, 0);
    check("sel b reset", rdv, 32'h200);
    foreach (rows[i])
    begin
      bus(1, rows[i][63:56], rows[i][55:24]);
      bus(0, rows[i][23:16], 0);
      check("readback", rdv, {16'h0, rows[i][15:0]});
    end
    // Clear is tried while the fault stands, then after it goes
    for (int d = 0; d < 7; d++)
      for (int c = 0; c < 6; c++)
      begin
        bus(1, d < 4 ? 32'h0 : 32'h4, 32'(c) << pos[d]);
        fault_det_in <= 7'(1 << d);
        tick(5);
        check("live action", obs, exp_out(d, c, 1));
        bus(1, 32'h8, 32'(1 << d));
        fault_det_in <= 7'h0;
        tick(5);
        check("held action", obs, exp_out(d, c, 0));
        bus(1, 32'h8, 32'(1 << d));
        bus(1, 32'h90, 32'h7f);
        tick(3);
        check("cleared", obs, 6'h20);
      end
    // Masked event still sets status; unmasking raises the line
    bus(1, 32'h0, 32'h100);
    bus(1, 32'h94, 32'h7f);
    fault_det_in <= 7'h02;
    tick(5);
    check("masked irq", irq_out, 0);
    bus(0, 32'h90, 0);
    check("irq status", rdv, 32'h2);
    bus(0, 32'h94, 0);
    check("irq mask", rdv, 32'h7f);
    bus(0, 32'h88, 0);
    check("fault status", rdv, 32'h2);
    bus(1, 32'h94, 32'h0);
    tick(2);
    check("unmasked irq", irq_out, 1);
    fault_det_in <= 7'h0;
    bus(1, 32'h90, 32'h2);
    tick(2);
    check("irq cleared", irq_out, 0);
    bus(1, 32'h4, 32'h0400);
    fault_det_in <= 7'h10;
    tick(5);
    check("overtemp pump", pump_stop_out, 1);
    fault_det_in <= 7'h0;
    // Second reset in mid-run
    bus(1, 32'h0, 32'h5555);
    reset_in <= 1;
    tick(6);
    reset_in <= 0;
    tick(1);
    check("rerun outputs", obs, 6'h20);
    bus(0, 32'h80, 0);
    check("sel a rerun", rdv, 32'h200);
    // Byte-sized write is refused
    hsize_in <= 3'h0;
    bus(1, 32'h0, 32'h1111);
    hsize_in <= fars_pkg::HSIZE_WORD;
    bus(0, 32'h80, 0);
    check("byte write refused", rdv, 32'h200);
    finish_test();
  end
endmodule
